/* logic/pcrs_read_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module pcrs_read_seq #(
  parameter int ROWS = pcrs_pkg::ROWS,
  parameter int unsigned PICK_TIMEOUT_CYC = pcrs_pkg::PICK_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  // host interface
  input wire logic fetch_req,
  output logic ready,
  output logic motion_fault,
  output logic read_fault,
  output logic column_data_strobe,
  output logic [ROWS-1:0] data_lines,
  output logic final_column_sample,
  // machine status inputs
  input wire logic hopper_ok,
  input wire logic power_ok,
  // sensors, asynchronous to the clock
  input wire logic pick_sensor,
  input wire logic [ROWS-1:0] row_light,
  input wire logic disc_pulse,
  // solenoid drives and sync control pulses
  output logic pick_sol,
  output logic pinch_sol,
  output logic pick_reset_pulse,
  output logic good_pick_reset
);
  typedef struct packed {
    pcrs_pkg::pcrs_fsm_t st;
    logic [31:0] tmo;
    logic [7:0] col;
    logic col_pend;
    logic [ROWS-1:0] row1;
    logic [ROWS-1:0] row2;
    logic pick1;
    logic pick2;
    logic disc1;
    logic disc2;
    logic disc3;
    logic pick_sol;
    logic pinch_sol;
    logic pick_rst;
    logic gp_rst;
    logic strobe;
    logic fcs;
    logic [ROWS-1:0] data;
    logic mfault;
    logic rfault;
    logic [pcrs_pkg::IRQ_W-1:0] ist;
    logic [pcrs_pkg::IRQ_W-1:0] imask;
    logic ap_v;
    logic ap_w;
    logic [7:0] ap_a;
    logic [31:0] rdata;
  } pcrs_state_t;

  pcrs_state_t r, n;
  logic ph_b, ph_c, ph_d, c1;
  logic accept, any_light, any_dark, tick, start_wr, ap_take;
  logic [31:0] rd_val;
  logic [pcrs_pkg::IRQ_W-1:0] ev;

  // four-phase timing source; only c1 paces the column logic
  pcrs_phase_gen u_phase (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ph_b(ph_b),
    .ph_c(ph_c),
    .ph_d(ph_d),
    .c1(c1)
  );

  // decoded conditions
  assign ready = !r.mfault && !r.rfault && hopper_ok && power_ok; // [R1]
  assign accept = (r.st == pcrs_pkg::PCRS_IDLE) && fetch_req && ready; // [R1]
  assign any_light = |r.row2;
  assign any_dark = ~&r.row2;
  assign tick = r.col_pend && c1; // [R5] [R10]
  assign ap_take = hsel && hready && htrans[1];
  assign start_wr = r.ap_v && r.ap_w && (r.ap_a == pcrs_pkg::REG_CTRL) &&
                    hwdata[pcrs_pkg::CTRL_START];

  // read mux, sampled in the address phase
  always_comb begin
    rd_val = 32'h0;
    case (haddr[7:0])
      pcrs_pkg::REG_STATUS: begin
        rd_val[pcrs_pkg::ST_READY] = ready;
        rd_val[pcrs_pkg::ST_BUSY] = r.st != pcrs_pkg::PCRS_IDLE;
        rd_val[pcrs_pkg::ST_MFAULT] = r.mfault;
        rd_val[pcrs_pkg::ST_RFAULT] = r.rfault;
        rd_val[pcrs_pkg::ST_PICK] = r.pick_sol;
        rd_val[pcrs_pkg::ST_PINCH] = r.pinch_sol;
        rd_val[pcrs_pkg::ST_COL_LSB +: 8] = r.col;
      end
      pcrs_pkg::REG_IRQ_STAT: rd_val[pcrs_pkg::IRQ_W-1:0] = r.ist;
      pcrs_pkg::REG_IRQ_MASK: rd_val[pcrs_pkg::IRQ_W-1:0] = r.imask;
      pcrs_pkg::REG_DATA: rd_val[ROWS-1:0] = r.data;
      default: rd_val = 32'h0;
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    n = r;
    ev = '0;
    n.pick_rst = 1'b0;
    n.gp_rst = 1'b0;
    n.strobe = 1'b0;
    n.fcs = 1'b0;
    // two-stage synchronisers, first stage read only by the second
    n.pick1 = pick_sensor; // [R17]
    n.pick2 = r.pick1;
    n.row1 = row_light; // [R17]
    n.row2 = r.row1;
    n.disc1 = disc_pulse; // [R17]
    n.disc2 = r.disc1;
    n.disc3 = r.disc2;
    // a disc edge waits for the next c1 phase; a new edge wins the clear
    n.col_pend = (r.col_pend && !c1) || (r.disc2 && !r.disc3); // [R5]
    // host bus address phase
    n.ap_v = ap_take;
    n.ap_w = hwrite;
    n.ap_a = haddr[7:0];
    if (ap_take) begin
      n.rdata = rd_val;
    end
    // start reset clears latched errors; a fault in the same cycle wins
    if (start_wr) begin
      n.mfault = 1'b0; // [R16]
      n.rfault = 1'b0; // [R16]
    end
    case (r.st)
      pcrs_pkg::PCRS_IDLE: begin
        n.tmo = 32'h0;
        if (accept) begin
          n.pick_sol = 1'b1; // [R2]
          n.pick_rst = 1'b1; // [R2]
          n.st = pcrs_pkg::PCRS_PICK;
        end
      end
      pcrs_pkg::PCRS_PICK: begin
        n.tmo = r.tmo + 32'h1;
        if (r.pick2) begin
          n.pick_sol = 1'b0;
          n.pinch_sol = 1'b1; // [R3]
          n.tmo = 32'h0;
          n.st = pcrs_pkg::PCRS_FEED;
        end else if (r.tmo >= PICK_TIMEOUT_CYC - 1) begin
          n.pick_sol = 1'b0;
          n.mfault = 1'b1; // [R15]
          ev[pcrs_pkg::IRQ_MOTION] = 1'b1;
          n.st = pcrs_pkg::PCRS_IDLE;
        end
      end
      pcrs_pkg::PCRS_FEED: begin
        // a card that never reaches the read station is a motion fault too
        n.tmo = r.tmo + 32'h1;
        if (!any_light) begin
          n.gp_rst = 1'b1; // [R4]
          n.col = pcrs_pkg::COL_DARK_CHK;
          n.col_pend = 1'b0;
          n.st = pcrs_pkg::PCRS_READ;
        end else if (r.tmo >= PICK_TIMEOUT_CYC - 1) begin
          n.pinch_sol = 1'b0;
          n.mfault = 1'b1;
          ev[pcrs_pkg::IRQ_MOTION] = 1'b1;
          n.st = pcrs_pkg::PCRS_IDLE;
        end
      end
      pcrs_pkg::PCRS_READ: begin
        if (tick) begin
          n.col = r.col + 8'h01; // [R6]
          if (r.col == pcrs_pkg::COL_DARK_CHK && any_light) begin
            n.rfault = 1'b1; // [R7] [R13]
            ev[pcrs_pkg::IRQ_READ] = 1'b1;
          end
          if (r.col >= pcrs_pkg::COL_FIRST && r.col <= pcrs_pkg::COL_LAST) begin
            n.strobe = 1'b1; // [R8] [R9]
            n.data = r.row2; // [R11] lit row is a hole
          end
          if (r.col == pcrs_pkg::COL_LIGHT_CHK) begin
            n.col = r.col;
            n.fcs = 1'b1;
            n.pinch_sol = 1'b0;
            ev[pcrs_pkg::IRQ_DONE] = 1'b1;
            n.st = pcrs_pkg::PCRS_IDLE;
            if (any_dark) begin
              n.rfault = 1'b1; // [R7] [R14]
              ev[pcrs_pkg::IRQ_READ] = 1'b1;
            end
          end
        end
      end
      default: n.st = pcrs_pkg::PCRS_IDLE;
    endcase
    // bus writes in the data phase
    if (r.ap_v && r.ap_w && r.ap_a == pcrs_pkg::REG_IRQ_MASK) begin
      n.imask = hwdata[pcrs_pkg::IRQ_W-1:0];
    end
    // sticky interrupt status, write one to clear, a new event wins
    if (r.ap_v && r.ap_w && r.ap_a == pcrs_pkg::REG_IRQ_STAT) begin
      n.ist = r.ist & ~hwdata[pcrs_pkg::IRQ_W-1:0];
    end
    n.ist = n.ist | ev;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs, all from flops except the handshake and level terms
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign irq = |(r.ist & r.imask);
  assign motion_fault = r.mfault;
  assign read_fault = r.rfault;
  assign column_data_strobe = r.strobe;
  assign data_lines = r.data; // [R12]
  assign final_column_sample = r.fcs;
  assign pick_sol = r.pick_sol;
  assign pinch_sol = r.pinch_sol;
  assign pick_reset_pulse = r.pick_rst;
  assign good_pick_reset = r.gp_rst;

  // checks
  logic [7:0] strobe_cnt;
  always_ff @(posedge clk_sys) begin
    if (!nrst || good_pick_reset) begin
      strobe_cnt <= 8'h0;
    end else if (column_data_strobe) begin
      strobe_cnt <= strobe_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_accept;
    r.st == pcrs_pkg::PCRS_IDLE && fetch_req && ready;
  endsequence
  sequence s_pick_started;
    pick_sol && pick_reset_pulse ##1 !pick_reset_pulse;
  endsequence

  property p_no_pick_unready;
    $rose(pick_sol) |-> $past(ready) && $past(fetch_req);
  endproperty
  a_no_pick_unready: assert property (p_no_pick_unready) // [R1]
    else $error("pick started without ready and fetch");

  property p_pick_reset;
    s_accept |=> s_pick_started;
  endproperty
  a_pick_reset: assert property (p_pick_reset) // [R2]
    else $error("accepted fetch did not pick with one reset pulse");

  property p_pinch;
    r.st == pcrs_pkg::PCRS_PICK && r.pick2 |=> pinch_sol && !pick_sol;
  endproperty
  a_pinch: assert property (p_pinch) // [R3]
    else $error("pick sensor did not produce pinch");

  property p_good_pick;
    good_pick_reset |-> r.col == 8'h00 && $past(r.st == pcrs_pkg::PCRS_FEED);
  endproperty
  a_good_pick: assert property (p_good_pick) // [R4]
    else $error("good pick reset outside feed");

  property p_col_step;
    r.st == pcrs_pkg::PCRS_READ && tick && r.col != 8'h54
      |=> r.col == $past(r.col) + 8'h01;
  endproperty
  a_col_step: assert property (p_col_step) // [R6]
    else $error("column counter did not step on disc pulse");

  // entry to read reloads column zero off the phase, so only moves inside
  property p_col_paced;
    r.st == pcrs_pkg::PCRS_READ && $past(r.st) == pcrs_pkg::PCRS_READ &&
      $changed(r.col) |-> $past(c1);
  endproperty
  a_col_paced: assert property (p_col_paced) // [R10]
    else $error("column moved off the c1 phase");

  property p_dark_chk;
    r.st == pcrs_pkg::PCRS_READ && tick && r.col == 8'h00 && any_light
      |=> read_fault && !ready;
  endproperty
  a_dark_chk: assert property (p_dark_chk) // [R13]
    else $error("light at dark check not faulted");

  property p_light_chk;
    r.st == pcrs_pkg::PCRS_READ && tick && r.col == 8'h54 && any_dark
      |=> read_fault && final_column_sample;
  endproperty
  a_light_chk: assert property (p_light_chk) // [R14]
    else $error("dark at light check not faulted");

  property p_eighty;
    final_column_sample |-> strobe_cnt == 8'h50;
  endproperty
  a_eighty: assert property (p_eighty) // [R8]
    else $error("card did not give eighty strobes");

  property p_strobe_data;
    column_data_strobe |-> data_lines == $past(r.row2) &&
      $past(r.col) >= 8'h01 && $past(r.col) <= 8'h50;
  endproperty
  a_strobe_data: assert property (p_strobe_data) // [R9]
    else $error("strobe loaded wrong data or column");

  property p_timeout;
    r.st == pcrs_pkg::PCRS_PICK && !r.pick2 &&
      r.tmo == PICK_TIMEOUT_CYC - 1 |=> motion_fault && !pick_sol;
  endproperty
  a_timeout: assert property (p_timeout) // [R15]
    else $error("pick timeout did not raise motion fault");

  property p_clear;
    start_wr && r.st == pcrs_pkg::PCRS_IDLE |=> !motion_fault && !read_fault;
  endproperty
  a_clear: assert property (p_clear) // [R16]
    else $error("start reset left an error latched");
endmodule
`default_nettype wire

/* logic/pcrs_pkg.sv */
// Contract
// R1 - accept a fetch only with no alarm, cards in hopper, power up
// R2 - on accept, drive pick solenoid and pulse pick_reset_pulse
// R3 - pick sensor arrival produces the pinch solenoid drive
// R4 - leading edge darkening read station issues good_pick_reset
// R5 - column timing comes from timing-disc pulses
// R6 - column counter advances once per synchronised disc pulse
// R7 - dark check at column 0, light check at column 84
// R8 - exactly one column_data_strobe per each of 80 columns
// R9 - each strobe loads the row pattern, at set columns only
// R10 - 1.2 MHz oscillator with three-phase logic times the block; the code uses a four-phase source and only c1 paces it
// R11 - lit sensor is a hole, dark is none, into data register
// R12 - data register drives the host data lines
// R13 - any light at dark check gives read fault, ready drops
// R14 - any dark at light check gives read fault, ready drops
// R15 - no pick sensor 250 ms after fetch gives motion_fault
// R16 - start reset clears every latched error
// R17 - pick, read station and disc inputs pass two-stage synchronisers
`default_nettype none
package pcrs_pkg;
  // clock and timing
  localparam longint CLK_HZ = 100_000_000;
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned OSC_KHZ = 1200;
  localparam int ACC_W = 17;
  localparam longint PICK_TIMEOUT_MS = 250;
  localparam int unsigned PICK_TIMEOUT_CYC =
    int'((PICK_TIMEOUT_MS * CLK_HZ) / 64'd1000);
  // card geometry
  localparam int ROWS = 12;
  localparam logic [7:0] COL_DARK_CHK = 8'h00;
  localparam logic [7:0] COL_FIRST = 8'h01;
  localparam logic [7:0] COL_LAST = 8'h50;
  localparam logic [7:0] COL_LIGHT_CHK = 8'h54;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  // control and status fields
  localparam int CTRL_START = 0;
  localparam int ST_READY = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_MFAULT = 2;
  localparam int ST_RFAULT = 3;
  localparam int ST_PICK = 4;
  localparam int ST_PINCH = 5;
  localparam int ST_COL_LSB = 8;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_MOTION = 0;
  localparam int IRQ_READ = 1;
  localparam int IRQ_DONE = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // sequencer states
  typedef enum logic [1:0] {
    PCRS_IDLE,
    PCRS_PICK,
    PCRS_FEED,
    PCRS_READ
  } pcrs_fsm_t;
endpackage
`default_nettype wire

/* logic/pcrs_phase_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module pcrs_phase_gen #(
  parameter int unsigned OSC_KHZ = pcrs_pkg::OSC_KHZ,
  parameter int unsigned CLK_KHZ = pcrs_pkg::CLK_KHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // phase enables, one cycle each, at 300 kHz / 4
  output logic ph_b,
  output logic ph_c,
  output logic ph_d,
  output logic c1
);
  localparam int AW = pcrs_pkg::ACC_W;

  typedef struct packed {
    logic [AW-1:0] acc;
    logic [1:0] div;
    logic [1:0] ph;
    logic [3:0] out;
  } pcrs_pg_t;

  pcrs_pg_t r, n;
  logic [AW-1:0] sum;

  // fractional accumulator gives the 1.2 MHz rate on average; jitter of
  // one system clock is harmless against the slow disc pulses
  always_comb begin
    n = r;
    n.out = 4'h0;
    sum = r.acc + AW'(OSC_KHZ);
    if (sum >= AW'(CLK_KHZ)) begin
      n.acc = sum - AW'(CLK_KHZ);
      n.div = r.div + 2'h1;
      if (r.div == 2'h3) begin
        n.ph = r.ph + 2'h1;
        n.out = 4'h1 << r.ph;
      end
    end else begin
      n.acc = sum;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ph_b = r.out[0];
  assign ph_c = r.out[1];
  assign ph_d = r.out[2];
  assign c1 = r.out[3];
endmodule
`default_nettype wire

/* tb/pcrs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcrs_host_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bench command, one cycle high asks for one card
  input wire logic fetch_go,
  // reader host lines
  output logic fetch_req,
  input wire logic column_data_strobe,
  input wire logic [11:0] data_lines,
  input wire logic final_column_sample,
  // columns gathered for the current card
  output logic [7:0] n_cols,
  output logic [80:1][11:0] cols,
  output logic card_end
);
  // request lasts one cycle, a refused one is simply lost
  always @(posedge clk_sys) begin
    fetch_req <= nrst & fetch_go;
  end

  // host latches lines only on the strobe, extra strobes still count
  always @(posedge clk_sys) begin
    if (!nrst || fetch_go) begin
      n_cols <= 8'h00;
      card_end <= 1'b0;
    end else begin
      if (column_data_strobe) begin
        n_cols <= n_cols + 8'h01;
        if (n_cols < 8'h50) cols[n_cols + 8'h01] <= data_lines;
      end
      if (final_column_sample) card_end <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/test_punched_card_read_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_punched_card_read_sequencer;
  localparam int TO = 200;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic fetch_go = 1'b0;
  logic hopper_ok = 1'b1;
  logic power_ok = 1'b1;
  logic pick_sensor = 1'b0;
  logic disc_pulse = 1'b0;
  logic [11:0] row_light = 12'hfff;
  logic hreadyout, hresp, irq, fetch_req, ready, motion_fault;
  logic read_fault, column_data_strobe, final_column_sample;
  logic pick_sol, pinch_sol, pick_reset_pulse, good_pick_reset;
  logic card_end;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [11:0] data_lines;
  logic [7:0] n_cols;
  logic [80:1][11:0] cols;
  int n_fail = 0;
  int samples_checked = 0;
  int n;

  always #5 clk_sys = ~clk_sys;

  // the one slave drives the bus ready
  pcrs_read_seq #(.PICK_TIMEOUT_CYC(TO)) i_pcrs_read_seq (
    .clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
    .fetch_req, .ready, .motion_fault, .read_fault, .column_data_strobe,
    .data_lines, .final_column_sample, .hopper_ok, .power_ok,
    .pick_sensor, .row_light, .disc_pulse, .pick_sol, .pinch_sol,
    .pick_reset_pulse, .good_pick_reset
  );

  pcrs_host_model i_pcrs_host_model (
    .clk_sys, .nrst, .fetch_go, .fetch_req, .column_data_strobe,
    .data_lines, .final_column_sample, .n_cols, .cols, .card_end
  );

  function automatic logic [31:0] b(input logic x);
    return {31'h0, x};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single word transfer, waits on ready in both phases
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, b(hresp));
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string what);
    bus(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return pick_sol;
      1: return pinch_sol;
      2: return good_pick_reset;
      default: return motion_fault;
    endcase
  endfunction

  // sampled on the falling edge so registered outputs have settled
  task automatic wait_on(input int s, input int lim, input string what);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (sig(s) !== 1'b1 && n < lim);
    chk(what, 32'h1, b(sig(s)));
  endtask

  task automatic fetch;
    @(posedge clk_sys);
    fetch_go <= 1'b1;
    @(posedge clk_sys);
    fetch_go <= 1'b0;
  endtask

  // one column just over a c1 period, so the tick lands before rows move
  task automatic disc(input logic [11:0] rows);
    @(posedge clk_sys);
    row_light <= rows;
    repeat (4) @(posedge clk_sys);
    disc_pulse <= 1'b1;
    repeat (4) @(posedge clk_sys);
    disc_pulse <= 1'b0;
    repeat (1336) @(posedge clk_sys);
  endtask

  function automatic logic [11:0] pat(input int k);
    if (k == 0) return 12'h000;
    if (k == 84) return 12'hffe;
    return 12'(k * 149);
  endfunction

  task automatic card_begin;
    fetch;
    wait_on(0, 10, "pick_sol");
    chk("pick_reset_pulse", 32'h1, b(pick_reset_pulse));
    @(posedge clk_sys);
    pick_sensor <= 1'b1;
    wait_on(1, 10, "pinch_sol");
    chk("sensor sync delay", 32'h1, b(n >= 3));
    chk("pick_sol off", 32'h0, b(pick_sol));
    @(posedge clk_sys);
    pick_sensor <= 1'b0;
    row_light <= 12'h000;
    wait_on(2, 10, "good_pick_reset");
  endtask

  task automatic t_regs;
    chk("ready", 32'h1, b(ready));
    rdchk(pcrs_pkg::REG_STATUS, 32'h1, "status");
    rdchk(pcrs_pkg::REG_IRQ_MASK, 32'h0, "irq_mask");
    bus(pcrs_pkg::REG_IRQ_MASK, 1'b1, 32'h5);
    rdchk(pcrs_pkg::REG_IRQ_MASK, 32'h5, "irq_mask");
    bus(pcrs_pkg::REG_IRQ_MASK, 1'b1, 32'h0);
    bus(8'h20, 1'b1, 32'hffff);
    rdchk(8'h20, 32'h0, "unmapped");
    $display("test regs done");
  endtask

  // each missing condition alone must hold the reader off
  task automatic t_refuse;
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      hopper_ok <= c[0];
      power_ok <= ~c[0];
      fetch;
      repeat (5) @(negedge clk_sys);
      chk("ready", 32'h0, b(ready));
      chk("pick_sol", 32'h0, b(pick_sol));
    end
    @(posedge clk_sys);
    hopper_ok <= 1'b1;
    power_ok <= 1'b1;
    $display("test refuse done");
  endtask

  task automatic t_timeout;
    fetch;
    wait_on(0, 10, "pick_sol");
    wait_on(3, TO + 20, "motion_fault");
    chk("timeout span", 32'h1, b(n >= TO - 2));
    chk("pick_sol", 32'h0, b(pick_sol));
    chk("irq masked", 32'h0, b(irq));
    rdchk(pcrs_pkg::REG_IRQ_STAT, 32'h1, "irq_stat");
    fetch;
    repeat (5) @(negedge clk_sys);
    chk("pick in alarm", 32'h0, b(pick_sol));
    bus(pcrs_pkg::REG_IRQ_MASK, 1'b1, 32'h7);
    @(negedge clk_sys);
    chk("irq", 32'h1, b(irq));
    bus(pcrs_pkg::REG_CTRL, 1'b1, 32'h1);
    @(negedge clk_sys);
    chk("motion_fault", 32'h0, b(motion_fault));
    chk("ready", 32'h1, b(ready));
    bus(pcrs_pkg::REG_IRQ_STAT, 1'b1, 32'h1);
    @(negedge clk_sys);
    chk("irq cleared", 32'h0, b(irq));
    $display("test timeout done");
  endtask

  // last column carries one dark row so the light check must trip
  task automatic t_card;
    card_begin;
    for (int k = 0; k <= 84; k++) begin
      disc(pat(k));
      if (k == 0) chk("dark check", 32'h0, b(read_fault));
      if (k == 1) chk("cols", 32'h1, {24'h0, n_cols});
    end
    chk("cols", 32'h50, {24'h0, n_cols});
    for (int k = 1; k <= 80; k++) begin
      chk("col data", {20'h0, pat(k)}, {20'h0, cols[k]});
    end
    chk("card end", 32'h1, b(card_end));
    chk("pinch_sol", 32'h0, b(pinch_sol));
    chk("read_fault", 32'h1, b(read_fault));
    chk("ready", 32'h0, b(ready));
    chk("irq", 32'h1, b(irq));
    rdchk(pcrs_pkg::REG_IRQ_STAT, 32'h6, "irq_stat");
    bus(pcrs_pkg::REG_CTRL, 1'b1, 32'h1);
    bus(pcrs_pkg::REG_IRQ_STAT, 1'b1, 32'h7);
    @(negedge clk_sys);
    chk("read_fault", 32'h0, b(read_fault));
    chk("irq", 32'h0, b(irq));
    @(posedge clk_sys);
    row_light <= 12'hfff;
    $display("test card done");
  endtask

  // a lit row at column zero, then a reset in mid card
  task automatic t_dark;
    card_begin;
    disc(12'h010);
    chk("read_fault", 32'h1, b(read_fault));
    chk("ready", 32'h0, b(ready));
    @(posedge clk_sys);
    nrst <= 1'b0;
    row_light <= 12'hfff;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk("pinch_sol", 32'h0, b(pinch_sol));
    chk("read_fault", 32'h0, b(read_fault));
    $display("test dark done");
  endtask

  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs;
    t_refuse;
    t_timeout;
    t_card;
    t_dark;
    close_out;
  end

  // a full card takes about 1.1 ms, so 3 ms means a hang
  initial begin
    #3_000_000;
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
